/* verilog/wml_store.sv */
// constants package and the writable microinstruction ram
package wml_pkg;
	// ============================================================
	// control store geometry
	localparam int CS_ADDR_W = 12;
	localparam int CS_WORDS = 4096;
	localparam logic [11:0] BASE_WORDS = 12'h200;
	localparam logic [11:0] WRAM_WORDS = 12'h100;
	localparam int WRAM_ADDR_W = 8;
	localparam int WORD_W = 16;
	localparam int MICRO_W = 64;
	localparam int HOLD_W = 48;
	// ============================================================
	// load port
	localparam logic IO_FN_PTR = 1'b0;
	localparam logic IO_FN_DATA = 1'b1;
	localparam logic [1:0] PACK_FIRST = 2'h0;
	localparam logic [1:0] PACK_LAST = 2'h3;
	localparam logic [15:0] SECOND_WORD_STEP = 16'h0001;
	// ============================================================
	// jump-to-store operations
	localparam logic [1:0] JOP_ENTER_PAGE = 2'h0;
	localparam logic [1:0] JOP_ENTER_VIRTUAL = 2'h1;
	localparam logic [1:0] JOP_ENTER_RESTRICTED = 2'h2;
	localparam logic [1:0] JOP_LEAVE_PAGE = 2'h3;
	// ============================================================
	// timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int XFER_TIME_NS = 2500;
	localparam int XFER_CYCLES = XFER_TIME_NS / CLK_PERIOD_NS;
	localparam int MICRO_TIME_NS = 280;
	localparam int MICRO_CYCLES = MICRO_TIME_NS / CLK_PERIOD_NS;
	localparam int XFER_CNT_W = 9;
	localparam int MICRO_CNT_W = 6;
	// ============================================================
	// jump sequencer states
	typedef enum logic [3:0]
	{
		WML_IDLE = 4'b0001,
		WML_FETCH_PTR = 4'b0010,
		WML_FETCH_TGT = 4'b0100,
		WML_WAIT = 4'b1000
	} wml_jstate_e;
endpackage

// ============================================================
// simple dual port ram, registered read
module wml_ram
#(
	parameter int WIDTH = 64,
	parameter int DEPTH = 256,
	parameter int AW = 8
)
(
	input wire logic clk_sys,
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [WIDTH-1:0] wr_data,
	input wire logic [AW-1:0] rd_addr,
	output logic [WIDTH-1:0] rd_data
);
	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk_sys)
	begin
		if (wr_en)
		begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end
endmodule

/* verilog/wml_loader.sv */
// writable microcode store loader, fetch port and jump-to-store sequencer

module wml_loader
	import wml_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic io_wr,
	input wire logic io_fn,
	input wire logic [WORD_W-1:0] io_data,
	input wire logic jmp_start,
	input wire logic [1:0] jmp_op,
	input wire logic [WORD_W-1:0] jmp_pc,
	input wire logic leave_restricted,
	input wire logic mem_rd_ack,
	input wire logic [WORD_W-1:0] mem_rd_data,
	input wire logic useq_req,
	input wire logic [CS_ADDR_W-1:0] useq_addr,
	output logic mem_rd_req,
	output logic [WORD_W-1:0] mem_addr,
	output logic jmp_busy,
	output logic jmp_trap,
	output logic xfer_valid,
	output logic [CS_ADDR_W-1:0] xfer_addr,
	output logic page_mode,
	output logic restricted_mode,
	output logic [WRAM_ADDR_W-1:0] load_ptr,
	output logic [1:0] pack_pos,
	output logic useq_ack,
	output logic useq_ext,
	output logic [MICRO_W-1:0] useq_data
);
	// ============================================================
	// load path
	logic [WRAM_ADDR_W-1:0] ld_ptr_r, ld_ptr_nxt;
	logic [1:0] pos_r, pos_nxt;
	logic [HOLD_W-1:0] hold_r, hold_nxt;
	logic wr_en;
	logic [MICRO_W-1:0] wr_data;

	always_comb
	begin
		ld_ptr_nxt = ld_ptr_r;
		pos_nxt = pos_r;
		hold_nxt = hold_r;
		wr_en = 1'b0;
		wr_data = {hold_r, io_data};
		if (io_wr)
		begin
			if (io_fn == IO_FN_PTR)
			begin
				// a fresh pointer drops any unfinished group
				ld_ptr_nxt = io_data[WRAM_ADDR_W-1:0];
				pos_nxt = PACK_FIRST;
			end
			else if (pos_r == PACK_LAST)
			begin
				wr_en = 1'b1;
				pos_nxt = PACK_FIRST;
				ld_ptr_nxt = ld_ptr_r + 1'b1;
			end
			else
			begin
				// shift left so the first word ends on top
				hold_nxt = {hold_r[HOLD_W-WORD_W-1:0], io_data};
				pos_nxt = pos_r + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			ld_ptr_r <= '0;
			pos_r <= PACK_FIRST;
			hold_r <= '0;
		end
		else
		begin
			ld_ptr_r <= ld_ptr_nxt;
			pos_r <= pos_nxt;
			hold_r <= hold_nxt;
		end
	end

	// ============================================================
	// microinstruction fetch
	logic f_busy_r, f_busy_nxt;
	logic [MICRO_CNT_W-1:0] f_cnt_r, f_cnt_nxt;
	logic [CS_ADDR_W-1:0] f_addr_r, f_addr_nxt;
	logic f_ack_r, f_ack_nxt;
	logic f_ext_r, f_ext_nxt;
	logic [MICRO_W-1:0] f_data_r, f_data_nxt;
	logic [MICRO_W-1:0] ram_rd;
	logic [CS_ADDR_W-1:0] ram_off;
	logic in_ram;

	assign ram_off = f_addr_r - BASE_WORDS;
	assign in_ram = (f_addr_r >= BASE_WORDS)
		&& (f_addr_r < BASE_WORDS + WRAM_WORDS);

	always_comb
	begin
		f_busy_nxt = f_busy_r;
		f_cnt_nxt = f_cnt_r;
		f_addr_nxt = f_addr_r;
		f_ack_nxt = 1'b0;
		f_ext_nxt = f_ext_r;
		f_data_nxt = f_data_r;
		if (!f_busy_r)
		begin
			if (useq_req)
			begin
				f_busy_nxt = 1'b1;
				f_addr_nxt = useq_addr;
				f_cnt_nxt = MICRO_CNT_W'(MICRO_CYCLES - 2);
			end
		end
		else if (f_cnt_r == '0)
		begin
			f_busy_nxt = 1'b0;
			f_ack_nxt = 1'b1;
			f_ext_nxt = (f_addr_r >= BASE_WORDS);
			// unpopulated extended locations read as zero
			f_data_nxt = in_ram ? ram_rd : '0;
		end
		else
		begin
			f_cnt_nxt = f_cnt_r - 1'b1;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			f_busy_r <= 1'b0;
			f_cnt_r <= '0;
			f_addr_r <= '0;
			f_ack_r <= 1'b0;
			f_ext_r <= 1'b0;
			f_data_r <= '0;
		end
		else
		begin
			f_busy_r <= f_busy_nxt;
			f_cnt_r <= f_cnt_nxt;
			f_addr_r <= f_addr_nxt;
			f_ack_r <= f_ack_nxt;
			f_ext_r <= f_ext_nxt;
			f_data_r <= f_data_nxt;
		end
	end

	wml_ram
	#(
		.WIDTH(MICRO_W),
		.DEPTH(int'(WRAM_WORDS)),
		.AW(WRAM_ADDR_W)
	)
	u_ram
	(
		.clk_sys(clk_sys),
		.wr_en(wr_en),
		.wr_addr(ld_ptr_r),
		.wr_data(wr_data),
		.rd_addr(ram_off[WRAM_ADDR_W-1:0]),
		.rd_data(ram_rd)
	);

	// ============================================================
	// jump-to-store sequencer
	wml_jstate_e st_r, st_nxt;
	logic [XFER_CNT_W-1:0] x_cnt_r, x_cnt_nxt;
	logic [1:0] op_r, op_nxt;
	logic req_r, req_nxt;
	logic [WORD_W-1:0] maddr_r, maddr_nxt;
	logic trap_r, trap_nxt;
	logic xv_r, xv_nxt;
	logic [CS_ADDR_W-1:0] tgt_r, tgt_nxt;
	logic page_r, page_nxt;
	logic restr_r, restr_nxt;

	always_comb
	begin
		st_nxt = st_r;
		x_cnt_nxt = x_cnt_r;
		op_nxt = op_r;
		req_nxt = req_r;
		maddr_nxt = maddr_r;
		trap_nxt = 1'b0;
		xv_nxt = 1'b0;
		tgt_nxt = tgt_r;
		page_nxt = page_r;
		restr_nxt = restr_r;
		if (leave_restricted)
		begin
			restr_nxt = 1'b0;
		end
		if (st_r != WML_IDLE && x_cnt_r != '1)
		begin
			x_cnt_nxt = x_cnt_r + 1'b1;
		end
		case (st_r)
			WML_IDLE:
			begin
				if (jmp_start)
				begin
					if (restr_r)
					begin
						trap_nxt = 1'b1;
					end
					else
					begin
						st_nxt = WML_FETCH_PTR;
						op_nxt = jmp_op;
						x_cnt_nxt = '0;
						req_nxt = 1'b1;
						maddr_nxt = jmp_pc + SECOND_WORD_STEP;
					end
				end
			end
			WML_FETCH_PTR:
			begin
				if (mem_rd_ack)
				begin
					// second word names where the entry address lives
					maddr_nxt = mem_rd_data;
					st_nxt = WML_FETCH_TGT;
				end
			end
			WML_FETCH_TGT:
			begin
				if (mem_rd_ack)
				begin
					tgt_nxt = mem_rd_data[CS_ADDR_W-1:0];
					req_nxt = 1'b0;
					st_nxt = WML_WAIT;
				end
			end
			WML_WAIT:
			begin
				// a slow memory simply stretches past the nominal time
				if (x_cnt_r >= XFER_CNT_W'(XFER_CYCLES - 2))
				begin
					xv_nxt = 1'b1;
					st_nxt = WML_IDLE;
					case (op_r)
						JOP_ENTER_PAGE: page_nxt = 1'b1;
						JOP_ENTER_VIRTUAL:
						begin
							page_nxt = 1'b1;
							restr_nxt = 1'b1;
						end
						JOP_ENTER_RESTRICTED: restr_nxt = 1'b1;
						JOP_LEAVE_PAGE: page_nxt = 1'b0;
						default: page_nxt = page_r;
					endcase
				end
			end
			default:
			begin
				st_nxt = WML_IDLE;
				req_nxt = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			st_r <= WML_IDLE;
			x_cnt_r <= '0;
			op_r <= JOP_ENTER_PAGE;
			req_r <= 1'b0;
			maddr_r <= '0;
			trap_r <= 1'b0;
			xv_r <= 1'b0;
			tgt_r <= '0;
			page_r <= 1'b0;
			restr_r <= 1'b0;
		end
		else
		begin
			st_r <= st_nxt;
			x_cnt_r <= x_cnt_nxt;
			op_r <= op_nxt;
			req_r <= req_nxt;
			maddr_r <= maddr_nxt;
			trap_r <= trap_nxt;
			xv_r <= xv_nxt;
			tgt_r <= tgt_nxt;
			page_r <= page_nxt;
			restr_r <= restr_nxt;
		end
	end

	// ============================================================
	// outputs, all from flops
	logic busy_r;

	always_ff @(posedge clk_sys)
	begin
		if (rst)
		begin
			busy_r <= 1'b0;
		end
		else
		begin
			busy_r <= (st_nxt != WML_IDLE);
		end
	end

	assign mem_rd_req = req_r;
	assign mem_addr = maddr_r;
	assign jmp_busy = busy_r;
	assign jmp_trap = trap_r;
	assign xfer_valid = xv_r;
	assign xfer_addr = tgt_r;
	assign page_mode = page_r;
	assign restricted_mode = restr_r;
	assign load_ptr = ld_ptr_r;
	assign pack_pos = pos_r;
	assign useq_ack = f_ack_r;
	assign useq_ext = f_ext_r;
	assign useq_data = f_data_r;
endmodule

/* verification/wml_props.sv */
// assertion checker watching the loader ports
module wml_props
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic io_wr,
	input wire logic io_fn,
	input wire logic [15:0] io_data,
	input wire logic jmp_start,
	input wire logic jmp_busy,
	input wire logic jmp_trap,
	input wire logic xfer_valid,
	input wire logic restricted_mode,
	input wire logic mem_rd_req,
	input wire logic useq_req,
	input wire logic [11:0] useq_addr,
	input wire logic useq_ack,
	input wire logic useq_ext,
	input wire logic [7:0] load_ptr,
	input wire logic [1:0] pack_pos
);
	timeunit 1ns;
	timeprecision 1ps;
	// ====
	// cycle counters since each accepted request
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);
	logic [4:0] fc_r;
	logic [10:0] jc_r;
	always_ff @(posedge clk_sys)
	begin
		if (rst)
			fc_r <= 5'h00;
		else if (useq_req && fc_r <= 5'h01)
			fc_r <= 5'h1c;
		else if (fc_r != 5'h00)
			fc_r <= fc_r - 5'h01;
		if (rst)
			jc_r <= 11'h000;
		else if (jmp_start && !jmp_busy)
			jc_r <= 11'h001;
		else if (xfer_valid)
			jc_r <= 11'h000;
		else if (jc_r != 11'h000)
			jc_r <= jc_r + 11'h001;
	end
	sequence s_take;
		jmp_start && !jmp_busy;
	endsequence
	property p_trap; s_take ##0 restricted_mode |=> jmp_trap; endproperty
	a_trap: assert property (p_trap)
		else $error("trap missing");
	property p_read; s_take ##0 !restricted_mode |=> mem_rd_req; endproperty
	a_read: assert property (p_read)
		else $error("pointer read missing");
	property p_xfer; xfer_valid |-> jc_r >= 11'h0fa; endproperty
	a_xfer: assert property (p_xfer)
		else $error("transfer too early");
	property p_fetch; useq_ack == (fc_r == 5'h01); endproperty
	a_fetch: assert property (p_fetch)
		else $error("fetch answer off time");
	property p_ext;
		useq_ack |-> useq_ext == ($past(useq_addr, 28) >= 12'h200);
	endproperty
	a_ext: assert property (p_ext)
		else $error("extended flag wrong");
	property p_pack; io_wr && io_fn |=> pack_pos == $past(pack_pos) + 2'h1;
	endproperty
	a_pack: assert property (p_pack)
		else $error("packing count wrong");
	property p_ptr;
		io_wr && !io_fn |=> load_ptr == $past(io_data[7:0]) && pack_pos == 2'h0;
	endproperty
	a_ptr: assert property (p_ptr)
		else $error("pointer not taken");
	property p_rst; $fell(rst) |-> pack_pos == 2'h0 && load_ptr == 8'h00;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset state wrong");
endmodule

bind wml_loader wml_props i_props (.*);

/* verification/wml_mem_model.sv */
// main memory model answering the jump sequencer reads
module wml_mem_model
(
	input wire logic clk_sys,
	input wire logic mem_rd_req,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] dly,
	output logic mem_rd_ack,
	output logic [15:0] mem_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [256];
	logic [7:0] cnt = 8'h00;
	initial mem_rd_ack = 1'b0;
	initial mem_rd_data = 16'h0000;
	// data toggles outside an ack so a stale word cannot pass
	always @(posedge clk_sys)
	begin
		mem_rd_ack <= 1'b0;
		mem_rd_data <= ~mem_rd_data;
		if (!mem_rd_req || mem_rd_ack)
			cnt <= 8'h00;
		else if (cnt < dly)
			cnt <= cnt + 8'h01;
		else
		begin
			mem_rd_ack <= 1'b1;
			mem_rd_data <= mem[mem_addr[7:0]];
		end
	end
endmodule

/* verification/tb.sv */
// random and corner-case bench for the microcode loader
module tb
	import wml_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic io_wr = 1'b0;
	logic io_fn = 1'b0;
	logic jmp_start = 1'b0;
	logic leave_restricted = 1'b0;
	logic useq_req = 1'b0;
	logic [15:0] io_data = 16'h0000;
	logic [15:0] jmp_pc = 16'h0000;
	logic [1:0] jmp_op = 2'h0;
	logic [11:0] useq_addr = 12'h000;
	logic [7:0] dly = 8'h00;
	logic [1:0] md = 2'h0;
	logic mem_rd_ack, mem_rd_req, jmp_busy, jmp_trap, xfer_valid, useq_ack;
	logic page_mode, restricted_mode, useq_ext;
	logic [15:0] mem_rd_data, mem_addr;
	logic [11:0] xfer_addr;
	logic [7:0] load_ptr;
	logic [1:0] pack_pos;
	logic [63:0] useq_data;
	int error_cnt = 0;
	int checks_done = 0;
	always #5 clk_sys = ~clk_sys;
	wml_loader i_dut (.*);
	wml_mem_model i_mem (.*);
	// ====
	// tasks
	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	function automatic logic [1:0] nmode(input logic [1:0] op, m);
		case (op)
			JOP_ENTER_PAGE: return {1'b1, m[0]};
			JOP_ENTER_VIRTUAL: return 2'h3;
			JOP_ENTER_RESTRICTED: return {m[1], 1'b1};
			default: return {1'b0, m[0]};
		endcase
	endfunction
	task automatic put(input logic f, input logic [15:0] d);
		io_wr = 1'b1;
		io_fn = f;
		io_data = d;
		@(negedge clk_sys);
	endtask
	// cycle one after the taking edge is the first one looked at
	task automatic waitfor(input bit s, output int n);
		n = 1;
		while ((s ? xfer_valid | jmp_trap : useq_ack) !== 1'b1 && n < 2000)
		begin
			@(negedge clk_sys);
			n++;
		end
		if (n >= 2000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	endtask
	task automatic fetch(input logic [11:0] a, input logic [63:0] d);
		int n;
		useq_req = 1'b1;
		useq_addr = a;
		@(negedge clk_sys);
		useq_req = 1'b0;
		waitfor(1'b0, n);
		chk(n, 28);
		chk(useq_ext, a >= 12'h200);
		chk(useq_data, d);
		@(negedge clk_sys);
	endtask
	task automatic jump(input logic [1:0] op, input bit trap);
		int n;
		logic [15:0] pc;
		logic [15:0] t;
		pc = 16'($urandom_range(0, 126));
		t = 16'($urandom);
		i_mem.mem[pc + 16'h0001] = pc + 16'h0080;
		i_mem.mem[pc + 16'h0080] = t;
		jmp_start = 1'b1;
		jmp_op = op;
		jmp_pc = pc;
		@(negedge clk_sys);
		jmp_start = 1'b0;
		chk(jmp_busy, !trap);
		if (!trap)
			chk(mem_addr, pc + 16'h0001);
		waitfor(1'b1, n);
		chk(jmp_trap, trap);
		if (trap)
			chk(n, 1);
		else
		begin
			chk(n == 250 || (dly != 8'h00 && n > 250), 1);
			chk(xfer_addr, t[11:0]);
			md = nmode(op, md);
		end
		chk({page_mode, restricted_mode}, md);
	endtask
	// ====
	// main sequence
	initial
	begin
		logic [15:0] w [8];
		logic [7:0] p;
		void'($urandom(441));
		repeat (8) @(negedge clk_sys);
		rst = 1'b0;
		chk({pack_pos, load_ptr, page_mode, restricted_mode}, 0);
		for (int k = 0; k < 2; k++)
		begin
			foreach (w[i]) w[i] = 16'($urandom);
			p = k ? 8'($urandom_range(2, 254)) : 8'hff;
			put(1'b0, {8'($urandom), p});
			put(1'b1, 16'($urandom));
			put(1'b0, {8'($urandom), p});
			foreach (w[i]) put(1'b1, w[i]);
			io_wr = 1'b0;
			@(negedge clk_sys);
			chk({pack_pos, load_ptr}, {2'h0, p + 8'h02});
			fetch({4'h2, p}, {w[0], w[1], w[2], w[3]});
			fetch({4'h2, p + 8'h01}, {w[4], w[5], w[6], w[7]});
		end
		fetch(12'h400, 0);
		fetch(12'h1ff, 0);
		jump(JOP_ENTER_PAGE, 1'b0);
		jump(JOP_LEAVE_PAGE, 1'b0);
		// slow memory pushes the transfer past its nominal time
		dly = 8'hc8;
		jump(JOP_ENTER_RESTRICTED, 1'b0);
		jump(JOP_ENTER_PAGE, 1'b1);
		leave_restricted = 1'b1;
		md[0] = 1'b0;
		@(negedge clk_sys);
		leave_restricted = 1'b0;
		chk(restricted_mode, 0);
		jump(JOP_ENTER_VIRTUAL, 1'b0);
		jump(JOP_LEAVE_PAGE, 1'b1);
		// reset in mid-group: the next four words must form one whole group
		put(1'b1, 16'($urandom));
		put(1'b1, 16'($urandom));
		io_wr = 1'b0;
		rst = 1'b1;
		@(negedge clk_sys);
		rst = 1'b0;
		md = 2'h0;
		chk({pack_pos, load_ptr, page_mode, restricted_mode}, 0);
		foreach (w[i]) w[i] = 16'($urandom);
		for (int i = 0; i < 4; i++) put(1'b1, w[i]);
		io_wr = 1'b0;
		@(negedge clk_sys);
		chk({pack_pos, load_ptr}, {2'h0, 8'h01});
		fetch(12'h200, {w[0], w[1], w[2], w[3]});
		tally_and_finish();
	end
endmodule
